// >>> src/rx_status_ctrl.v
// Purpose : builds the per-frame receive status word, pushes it into the
//           status fifo, halts and restarts the receiver, raises the
//           receive error flag; registers reached over APB
// Assumes : frame side byte strobes synchronous to sys_clk_i; frame ends
//           when rx_dv_i falls, crc and dribble inputs valid that cycle
// Notes   : zero wait state APB slave, unmapped addresses answer pslverr
// Behaviour
// RULE1 - status bits 9:8 and 0 read zero
// RULE2 - bit 7 flags frame over 1518 bytes
// RULE3 - bit 6 flags late collision
// RULE4 - bit 5 set when type field exceeds 1500
// RULE5 - frame type clear for frames under 14 bytes
// RULE6 - bit 4 flags receive watchdog expiry
// RULE7 - bit 3 flags receive error during frame
// RULE8 - bit 2 flags dribble bits per mode
// RULE9 - dribble suppressed when late collision set
// RULE10 - dribble with good crc is valid frame
// RULE11 - bit 1 flags crc mismatch or receive error
// RULE12 - host ignores crc bit in bad frames
// RULE13 - host clears enable bit to halt
// RULE14 - pulse halted interrupt once receiver stops
// RULE15 - host may flush, then re-enables receiver
// RULE16 - error flag on underruns or status overrun
// RULE17 - receiver keeps running after error flag
// RULE18 - host finds and recovers error cause
// RULE19 - bit 15 is or of 11,7,6,1
// RULE20 - bits 29:16 carry frame size
// RULE21 - whole status word pushed once per frame
`timescale 1ns/1ns
`include "rx_stat_defines.vh"
module rx_status_ctrl #(
  parameter WDOG_LIMIT = `WDOG_BYTES,   // watchdog byte limit, 2048..2560
  parameter FIFO_AW    = 4              // log2 of status fifo depth
) (
  input  wire        sys_clk_i,         // system clock, 25 MHz
  input  wire        arst_n_i,          // async reset, active low
  // apb slave
  input  wire        psel,              // slave select
  input  wire        penable,           // access phase
  input  wire        pwrite,            // write direction
  input  wire [7:0]  paddr,             // byte address
  input  wire [31:0] pwdata,            // write data
  output wire        pready,            // always ready
  output wire        pslverr,           // unmapped access
  output reg  [31:0] prdata,            // read data
  // frame side from the mac receive path
  input  wire        rx_dv_i,           // frame in progress
  input  wire        rx_byte_valid_i,   // one byte received
  input  wire [7:0]  rx_byte_i,         // received byte
  input  wire        rx_er_i,           // mii receive error
  input  wire        rx_col_i,          // collision seen
  input  wire        rx_crc_ok_i,       // fcs matched, at frame end
  input  wire [2:0]  rx_dribble_i,      // leftover bits, at frame end
  input  wire        mode_10m_i,        // 1 = 10 Mbps, 0 = mii mode
  input  wire        filt_fail_i,       // address filter failed
  input  wire        bcast_i,           // broadcast destination
  input  wire        mcast_i,           // multicast destination
  input  wire        len_err_i,         // length field mismatch
  input  wire        data_underrun_i,   // host underran data fifo
  output wire        rx_accept_o,       // frame logic may take frames
  output reg         receiver_halted_interrupt_o, // halt pulse
  output wire        receive_error_flag_o         // sticky error level
);

  // ****************************************
  // declarations
  // ****************************************
  reg         receive_enable_bit_reg;   // software enable
  reg         err_flag_reg;             // sticky receive error
  reg  [1:0]  state_reg;                // receiver control state
  reg  [1:0]  state_next;               // next control state
  reg         in_frame_reg;             // accepted frame under way
  reg         er_seen_reg;              // receive error seen
  reg         col_seen_reg;             // late collision seen
  reg  [7:0]  type_hi_reg;              // type field high byte
  reg  [7:0]  type_lo_reg;              // type field low byte
  reg         push_reg;                 // push status this cycle
  reg  [31:0] word_reg;                 // status word to push
  reg         rd_empty_reg;             // empty seen in setup cycle
  reg  [31:0] word_next;                // assembled status word
  wire [13:0] byte_cnt;                 // bytes so far
  wire        frame_start;              // accepted frame begins
  wire        frame_end;                // accepted frame finishes
  wire        setup_ph;                 // apb setup cycle
  wire        access_ph;                // apb access completes
  wire        hit_ctrl;                 // control register hit
  wire        hit_state;                // state register hit
  wire        hit_status;               // status port hit
  wire        pop_req;                  // host status read
  wire        flush_req;                // flush written while stopped
  wire        underrun;                 // status read when empty
  wire        overrun;                  // push into full fifo
  wire [31:0] head;                     // fifo head word
  wire        fifo_empty;               // fifo holds nothing
  wire        fifo_full;                // fifo has no room
  wire [FIFO_AW:0] fifo_lvl;            // words in fifo
  wire [15:0] type_field;               // length/type field
  wire        dribble_hit;              // leftover bits qualify

  // ****************************************
  // apb decode
  // ****************************************
  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign hit_ctrl   = (paddr == `ADDR_RX_CTRL);
  assign hit_state  = (paddr == `ADDR_RX_STATE);
  assign hit_status = (paddr == `ADDR_RX_STATUS);
  assign pready     = 1'b1;
  assign pslverr    = access_ph && !(hit_ctrl || hit_state || hit_status);
  assign pop_req    = access_ph && !pwrite && hit_status;
  // flush only acts once the receiver has come to rest
  assign flush_req  = access_ph && pwrite && hit_ctrl && pwdata[`CTRL_FLUSH_BIT]
                      && (state_reg == `RXS_STOPPED); // [RULE15]
  // empty is judged at setup so the returned word and the pop agree
  assign underrun   = pop_req && rd_empty_reg;
  assign overrun    = push_reg && fifo_full;

  // ****************************************
  // apb registers and read data
  // ****************************************
  // read data latched in the setup cycle, shown in the access cycle
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata                 <= 32'h0000_0000;
      rd_empty_reg           <= 1'b1;
      receive_enable_bit_reg <= `CTRL_RESET;
    end else begin
      if (setup_ph) begin
        rd_empty_reg <= fifo_empty;
        if (pwrite) begin
          prdata <= 32'h0000_0000;
        end else if (hit_ctrl) begin
          prdata <= {31'h0000_0000, receive_enable_bit_reg};
        end else if (hit_state) begin
          prdata <= {16'h0000, {(8-FIFO_AW-1){1'b0}}, fifo_lvl, 6'h00,
                     (state_reg == `RXS_STOPPED), err_flag_reg};
        end else if (hit_status && !fifo_empty) begin
          prdata <= head;
        end else begin
          // unmapped or empty status port reads zero
          prdata <= 32'h0000_0000;
        end
      end
      // host clears or sets the enable to halt or resume
      if (access_ph && pwrite && hit_ctrl) begin
        receive_enable_bit_reg <= pwdata[`CTRL_EN_BIT]; // [RULE13]
      end
    end
  end

  // ****************************************
  // receive error flag
  // ****************************************
  // write one to clear; a new event in the same cycle wins over the clear
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_flag_reg <= 1'b0;
    end else if (data_underrun_i || underrun || overrun) begin
      err_flag_reg <= 1'b1; // [RULE16]
    end else if (access_ph && pwrite && hit_state && pwdata[`STATE_ERR_BIT]) begin
      err_flag_reg <= 1'b0;
    end
  end

  assign receive_error_flag_o = err_flag_reg;

  // ****************************************
  // receiver control state machine
  // ****************************************
  // the error flag never enters here, so reception carries on [RULE17]
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `RXS_STOPPED: begin
        if (receive_enable_bit_reg) begin
          state_next = `RXS_RUN;
        end
      end
      `RXS_RUN: begin
        if (!receive_enable_bit_reg) begin
          state_next = `RXS_DRAIN;
        end
      end
      `RXS_DRAIN: begin
        // a frame under way is finished before the halt
        if (!in_frame_reg || frame_end) begin
          state_next = `RXS_STOPPED;
        end
      end
      default: begin
        state_next = `RXS_STOPPED;
      end
    endcase
  end

  // state register and one-cycle halt pulse
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg                   <= `RXS_STOPPED;
      receiver_halted_interrupt_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      receiver_halted_interrupt_o <= (state_reg == `RXS_DRAIN) &&
                                     (state_next == `RXS_STOPPED); // [RULE14]
    end
  end

  assign rx_accept_o = (state_reg == `RXS_RUN);

  // ****************************************
  // frame tracking
  // ****************************************
  // frames only start while running; a frame already started while
  // draining is still finished so its status is not lost
  assign frame_start = rx_dv_i && !in_frame_reg && rx_accept_o;
  assign frame_end   = in_frame_reg && !rx_dv_i;

  sat_counter #(
    .WIDTH (14)
  ) u_byte_cnt (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (frame_end),
    .inc_i     ((in_frame_reg || frame_start) && rx_dv_i && rx_byte_valid_i),
    .count_o   (byte_cnt)
  );

  // per-frame sticky observations
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_frame_reg <= 1'b0;
      er_seen_reg  <= 1'b0;
      col_seen_reg <= 1'b0;
      type_hi_reg  <= 8'h00;
      type_lo_reg  <= 8'h00;
    end else if (frame_start) begin
      in_frame_reg <= 1'b1;
      er_seen_reg  <= rx_er_i;
      col_seen_reg <= 1'b0;
      type_hi_reg  <= 8'h00;
      type_lo_reg  <= 8'h00;
    end else if (in_frame_reg) begin
      if (!rx_dv_i) begin
        in_frame_reg <= 1'b0;
      end
      if (rx_dv_i && rx_er_i) begin
        er_seen_reg <= 1'b1; // [RULE7]
      end
      // only a collision past the window counts as late
      if (rx_dv_i && rx_col_i && (byte_cnt >= `COL_WINDOW_BYTES)) begin
        col_seen_reg <= 1'b1; // [RULE3]
      end
      if (rx_dv_i && rx_byte_valid_i && (byte_cnt == `TYPE_HI_INDEX)) begin
        type_hi_reg <= rx_byte_i;
      end
      if (rx_dv_i && rx_byte_valid_i && (byte_cnt == `TYPE_LO_INDEX)) begin
        type_lo_reg <= rx_byte_i;
      end
    end
  end

  // ****************************************
  // status word assembly
  // ****************************************
  assign type_field  = {type_hi_reg, type_lo_reg};
  // mii mode needs exactly four leftover bits, 10 Mbps three or more
  assign dribble_hit = mode_10m_i ? (rx_dribble_i >= `DRIB_10M_BITS)
                                  : (rx_dribble_i == `DRIB_MII_BITS); // [RULE8]

  // reserved positions stay at their zero default [RULE1]
  always @* begin
    word_next = 32'h0000_0000;
    word_next[`ST_FILT_FAIL]  = filt_fail_i;
    word_next[`ST_LEN_MSB:`ST_LEN_LSB] = byte_cnt; // [RULE20]
    word_next[`ST_BCAST]      = bcast_i;
    word_next[`ST_LEN_ERR]    = len_err_i;
    word_next[`ST_RUNT]       = (byte_cnt < `COL_WINDOW_BYTES);
    word_next[`ST_MCAST]      = mcast_i;
    // indication only; the frame is never cut short
    word_next[`ST_TOO_LONG]   = (byte_cnt > `MAX_FRAME_BYTES); // [RULE2]
    word_next[`ST_LATE_COL]   = col_seen_reg;
    // type bit needs the whole type field, so frames under 14 bytes leave it clear
    word_next[`ST_FRAME_TYPE] = (byte_cnt >= `TYPE_MIN_BYTES) &&
                                (type_field > `TYPE_THRESHOLD); // [RULE4] [RULE5]
    // the byte count is the watchdog; reception continues past it
    word_next[`ST_WDOG]       = ({18'h00000, byte_cnt} > WDOG_LIMIT); // [RULE6]
    word_next[`ST_MII_ERR]    = er_seen_reg;
    // a late collision masks the dribble indication; with a good crc
    // the dribble bit alone leaves the frame valid [RULE9] [RULE10]
    word_next[`ST_DRIBBLE]    = dribble_hit && !col_seen_reg;
    // host disregards this bit for runt, late collision, watchdog [RULE12]
    word_next[`ST_CRC_ERR]    = !rx_crc_ok_i || er_seen_reg; // [RULE11]
    word_next[`ST_ERR_SUM]    = word_next[`ST_RUNT] | word_next[`ST_TOO_LONG] |
                                word_next[`ST_LATE_COL] |
                                word_next[`ST_CRC_ERR]; // [RULE19]
  end

  // the finished word is registered and pushed as one entry
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      push_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
    end else begin
      push_reg <= frame_end; // [RULE21]
      if (frame_end) begin
        word_reg <= word_next;
      end
    end
  end

  // ****************************************
  // status fifo
  // ****************************************
  status_fifo #(
    .WIDTH (32),
    .AW    (FIFO_AW)
  ) u_status_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .flush_i     (flush_req),
    .push_i      (push_reg),
    .push_data_i (word_reg),
    .pop_i       (pop_req && !rd_empty_reg),
    .head_o      (head),
    .empty_o     (fifo_empty),
    .full_o      (fifo_full),
    .level_o     (fifo_lvl)
  );

endmodule

// >>> src/rx_stat_defines.vh
// Purpose : shared constants of the receive status and control block
// Assumes : included by bare name from the rx_status_ctrl module only
// Notes   : offsets are APB byte addresses, one aligned 32-bit word each
`ifndef RX_STAT_DEFINES_VH
`define RX_STAT_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_RX_CTRL      8'h00
`define ADDR_RX_STATE     8'h04
`define ADDR_RX_STATUS    8'h08

// ****************************************
// control and state fields
// ****************************************
`define CTRL_EN_BIT       0
`define CTRL_FLUSH_BIT    1
`define STATE_ERR_BIT     0
`define STATE_HALT_BIT    1
`define STATE_LVL_LSB     8
`define CTRL_RESET        1'b0

// ****************************************
// status word field positions
// ****************************************
`define ST_FILT_FAIL      30
`define ST_LEN_MSB        29
`define ST_LEN_LSB        16
`define ST_ERR_SUM        15
`define ST_BCAST          13
`define ST_LEN_ERR        12
`define ST_RUNT           11
`define ST_MCAST          10
`define ST_TOO_LONG       7
`define ST_LATE_COL       6
`define ST_FRAME_TYPE     5
`define ST_WDOG           4
`define ST_MII_ERR        3
`define ST_DRIBBLE        2
`define ST_CRC_ERR        1

// ****************************************
// frame size limits in bytes, dribble limits in bits
// ****************************************
`define MAX_FRAME_BYTES   14'd1518
`define COL_WINDOW_BYTES  14'd64
`define TYPE_MIN_BYTES    14'd14
`define TYPE_THRESHOLD    16'h05DC
`define TYPE_HI_INDEX     14'd12
`define TYPE_LO_INDEX     14'd13
`define WDOG_BYTES        2048
`define DRIB_MII_BITS     3'd4
`define DRIB_10M_BITS     3'd3

// ****************************************
// receiver control states
// ****************************************
`define RXS_STOPPED       2'b00
`define RXS_RUN           2'b01
`define RXS_DRAIN         2'b10

`endif

// >>> src/sat_counter.v
// Purpose : saturating up counter with synchronous clear
// Assumes : clear has priority over increment
// Notes   : holds at all ones so a long frame never wraps its size
`timescale 1ns/1ns
module sat_counter #(
  parameter WIDTH = 14                  // counter width
) (
  input  wire             sys_clk_i,    // system clock
  input  wire             arst_n_i,     // async reset, active low
  input  wire             clear_i,      // synchronous clear
  input  wire             inc_i,        // count one step
  output wire [WIDTH-1:0] count_o       // current count
);

  reg [WIDTH-1:0] cnt_reg;              // count value

  // ****************************************
  // counter
  // ****************************************
  // clear first, then step unless already saturated
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (inc_i && (cnt_reg != {WIDTH{1'b1}})) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign count_o = cnt_reg;

endmodule

// >>> src/status_fifo.v
// Purpose : synchronous FIFO holding complete receive status words
// Assumes : push when full and pop when empty are dropped
// Notes   : caller flags those cases as overrun and underrun
`timescale 1ns/1ns
module status_fifo #(
  parameter WIDTH = 32,                 // word width
  parameter AW    = 4                   // log2 of depth
) (
  input  wire             sys_clk_i,    // system clock
  input  wire             arst_n_i,     // async reset, active low
  input  wire             flush_i,      // empty the fifo
  input  wire             push_i,       // write one word
  input  wire [WIDTH-1:0] push_data_i,  // word to write
  input  wire             pop_i,        // drop head word
  output wire [WIDTH-1:0] head_o,       // head word
  output wire             empty_o,      // no words held
  output wire             full_o,       // no room left
  output wire [AW:0]      level_o       // words held
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];    // storage array
  reg [AW:0]      wr_ptr_reg;           // write pointer with wrap bit
  reg [AW:0]      rd_ptr_reg;           // read pointer with wrap bit
  wire            do_push;              // accepted write
  wire            do_pop;               // accepted read

  assign level_o = wr_ptr_reg - rd_ptr_reg;
  assign empty_o = (wr_ptr_reg == rd_ptr_reg);
  assign full_o  = (level_o == (1 << AW));
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign head_o  = mem[rd_ptr_reg[AW-1:0]];

  // ****************************************
  // storage, no reset needed on the data
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wr_ptr_reg[AW-1:0]] <= push_data_i;
    end
  end

  // ****************************************
  // pointers
  // ****************************************
  // flush returns both pointers to their reset state
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// >>> sim/rx_status_ctrl_properties.sv
// Purpose : concurrent checks on the receive status and control block
// Assumes : bound to rx_status_ctrl, status port read at byte address 08
// Notes   : status words are judged in the access cycle of a status read
`timescale 1ns/1ns
module rx_status_ctrl_chk #(
  parameter WDOG_LIMIT = 2048,  // watchdog byte limit
  parameter FIFO_AW    = 4      // status fifo depth log2
) (
  input wire        sys_clk_i,
  input wire        arst_n_i,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        data_underrun_i,
  input wire        rx_accept_o,
  input wire        receiver_halted_interrupt_o,
  input wire        receive_error_flag_o
);
  // access-cycle decodes; write and pop act on these edges
  wire st_rd  = psel && penable && !pwrite && (paddr == 8'h08);
  wire clr_wr = psel && penable && pwrite && (paddr == 8'h04) && pwdata[0];
  wire ctl_wr = psel && penable && pwrite && (paddr == 8'h00);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_rsv_zero: assert property (st_rd |-> prdata[9:8] == 2'h0 && !prdata[0])
    else $error("reserved bits set");
  a_err_summary: assert property (st_rd |->
    prdata[15] == (prdata[11] | prdata[7] | prdata[6] | prdata[1]))
    else $error("error summary bit wrong");
  a_runt_type: assert property (st_rd && prdata[29:16] < 14 |-> !prdata[5])
    else $error("frame type set on runt");
  a_drib_late: assert property (st_rd && prdata[6] |-> !prdata[2])
    else $error("dribble set with late collision");
  a_too_long: assert property (st_rd |-> prdata[7] == (prdata[29:16] > 1518))
    else $error("too long bit wrong");
  a_wdog_len: assert property (st_rd |-> prdata[4] == (prdata[29:16] > WDOG_LIMIT))
    else $error("watchdog bit wrong");
  a_mii_crc: assert property (st_rd && prdata[3] |-> prdata[1])
    else $error("crc bit missing");
  a_halt_pulse: assert property (receiver_halted_interrupt_o |->
    !rx_accept_o ##1 !receiver_halted_interrupt_o)
    else $error("halt pulse malformed");
  a_err_sticky: assert property (receive_error_flag_o && !clr_wr |=> receive_error_flag_o)
    else $error("error flag dropped");
  a_underrun_flag: assert property (data_underrun_i |=> receive_error_flag_o)
    else $error("data underrun not flagged");
  a_keep_running: assert property ((!ctl_wr)[*3] ##0
    ($rose(receive_error_flag_o) && rx_accept_o) |=> rx_accept_o)
    else $error("receiver stopped by error");
  c_halt: cover property (receiver_halted_interrupt_o);
  c_drib: cover property (st_rd && prdata[2]);
  c_err: cover property ($rose(receive_error_flag_o));
endmodule
bind rx_status_ctrl rx_status_ctrl_chk #(.WDOG_LIMIT(WDOG_LIMIT), .FIFO_AW(FIFO_AW)) u_chk (.*);

// >>> sim/mac_rx_model.sv
// Purpose : behavioural mac receive path feeding frames to the status block
// Assumes : one byte per clock while a frame is in progress
// Notes   : end flags invert after their cycle so stale values never pass
`timescale 1ns/1ns
module mac_rx_model (
  input  wire logic  clk_i,   // system clock
  output logic       dv_o,    // frame in progress
  output logic       bv_o,    // byte strobe
  output logic [7:0] byte_o,  // frame byte
  output logic       er_o,    // receive error
  output logic       col_o,   // collision
  output logic       ok_o,    // fcs good, end cycle
  output logic [2:0] drib_o,  // leftover bits, end cycle
  output logic       m10_o,   // 10 Mbps mode
  output logic [3:0] misc_o   // filter, bcast, len err, mcast
);
  initial {dv_o, bv_o, byte_o, er_o, col_o, ok_o, drib_o, m10_o, misc_o} = '0;
  // bytes 12 and 13 carry the type field; eb and cb pick error and collision bytes
  task send(input int l, input logic [15:0] tv, input int eb, input int cb,
            input logic ok, input logic [2:0] d, input logic m, input logic [3:0] x);
    for (int i = 0; i < l; i++) begin
      @(posedge clk_i);
      dv_o   <= 1'b1;
      bv_o   <= 1'b1;
      byte_o <= (i == 12) ? tv[15:8] : (i == 13) ? tv[7:0] : i[7:0];
      er_o   <= (i == eb);
      col_o  <= (i == cb);
      m10_o  <= m;
    end
    @(posedge clk_i);
    dv_o   <= 1'b0;
    bv_o   <= 1'b0;
    er_o   <= 1'b0;
    col_o  <= 1'b0;
    byte_o <= ~byte_o;
    ok_o   <= ok;
    drib_o <= d;
    misc_o <= x;
    @(posedge clk_i);
    ok_o   <= ~ok;
    drib_o <= ~d;
    misc_o <= ~x;
  endtask
endmodule

// >>> sim/testbench.sv
// Purpose : self-checking bench for the receive status and control block
// Assumes : apb master tasks, frames from mac_rx_model
// Notes   : status fifo shrunk to four words so overrun is quick to reach
`timescale 1ns/1ns
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin num_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, x); end end
module testbench;
  localparam int WD = 2048;      // watchdog limit handed to the design
  localparam int NONE = 99999;   // no error or collision byte
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic data_underrun_i = 1'b0, e;
  wire pready, pslverr, rx_accept_o, halt, err, dv, bv, er, col, ok, m10;
  wire [31:0] prdata;
  wire [7:0] rbyte;
  wire [2:0] drib;
  wire [3:0] misc;
  int num_errors = 0, check_count = 0, i;
  always #20 sys_clk_i = ~sys_clk_i;
  mac_rx_model u_mac_rx_model (.clk_i(sys_clk_i), .dv_o(dv), .bv_o(bv), .byte_o(rbyte),
    .er_o(er), .col_o(col), .ok_o(ok), .drib_o(drib), .m10_o(m10), .misc_o(misc));
  rx_status_ctrl #(.WDOG_LIMIT(WD), .FIFO_AW(2)) u_rx_status_ctrl (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .rx_dv_i(dv),
    .rx_byte_valid_i(bv), .rx_byte_i(rbyte), .rx_er_i(er), .rx_col_i(col),
    .rx_crc_ok_i(ok), .rx_dribble_i(drib), .mode_10m_i(m10), .filt_fail_i(misc[3]),
    .bcast_i(misc[2]), .mcast_i(misc[0]), .len_err_i(misc[1]),
    .data_underrun_i(data_underrun_i), .rx_accept_o(rx_accept_o),
    .receiver_halted_interrupt_o(halt), .receive_error_flag_o(err));
  // apb transfer, access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    @(posedge sys_clk_i);
    while (pready !== 1'b1) @(posedge sys_clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(e, 1'b0)
  endtask
  // send one frame, pop its status word, compare with the word the rules give
  task run(int l, logic [15:0] tv, int eb = NONE, int cb = NONE, logic ok = 1'b1,
           logic [2:0] d = 3'h0, logic m = 1'b0, logic [3:0] x = 4'h0);
    logic [31:0] s;
    logic lc;
    u_mac_rx_model.send(l, tv, eb, cb, ok, d, m, x);
    lc = (cb < l) && (cb >= 64);
    s = {1'b0, x[3], l[13:0], 2'h0, x[2:1], l < 64, x[0], 2'h0, l > 1518, lc,
         (l >= 14) && (tv > 16'h05DC), l > WD, eb < l, 3'h0};
    s[2] = (m ? d >= 3'h3 : d == 3'h4) && !lc;
    s[1] = !ok || (eb < l);
    s[15] = s[11] | s[7] | s[6] | s[1];
    rd(8'h08, s);
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h2);
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({e, r}, 33'h100000000)
    u_mac_rx_model.send(64, 16'h0800, NONE, NONE, 1'b1, 3'h0, 1'b0, 4'h0);
    rd(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    `CHK(rx_accept_o, 1'b1)
    run(64, 16'h0800, NONE, NONE, 1'b1, 3'h4, 1'b0, 4'hA);
    run(60, 16'h05DC, NONE, NONE, 1'b0, 3'h0, 1'b0, 4'h5);
    run(13, 16'hFFFF);
    run(14, 16'h05DD);
    run(100, 16'h0600, 50);
    run(100, 16'h0600, NONE, 80, 1'b1, 3'h4);
    run(100, 16'h0600, NONE, 63, 1'b1, 3'h4);
    run(90, 16'h0000, NONE, NONE, 1'b1, 3'h3, 1'b1);
    run(90, 16'h0000, NONE, NONE, 1'b1, 3'h3);
    run(1518, 16'h0800);
    run(1519, 16'h0800);
    run(2049, 16'h0800, NONE, NONE, 1'b0);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    @(posedge sys_clk_i);
    data_underrun_i <= 1'b1;
    @(posedge sys_clk_i);
    data_underrun_i <= 1'b0;
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    repeat (5) u_mac_rx_model.send(64, 16'h0800, NONE, NONE, 1'b1, 3'h0, 1'b0, 4'h0);
    rd(8'h04, 32'h401);
    wr(8'h00, 32'h0);
    for (i = 0; i < 50 && halt !== 1'b1; i++) @(posedge sys_clk_i);
    `CHK(halt, 1'b1)
    rd(8'h04, 32'h403);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    run(64, 16'h0800);
    give_verdict;
  end
endmodule
